// >>> ufc_udpd_cfg.sv
// ultra-deep sleep entry/wake and nonvolatile page-size configuration control
// assumes spi pins synchronous to core_clk; ext_busy flags other self-timed work
`timescale 1ns/1ps
module ufc_udpd_cfg
    import ufc_pkg::*;
#(
    parameter logic [TMR_W-1:0] EXIT_CYC = TMR_W'(EXIT_CYC_I),
    parameter logic [TMR_W-1:0] CFG_CYC  = TMR_W'(CFG_CYC_I)
)(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // spi pins
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       si,
    // rest of the device
    input  wire logic       ext_busy,
    input  wire logic       nv_size_256,
    // status to the rest of the device
    output logic            device_idle_flag,
    output logic            cmd_enable,
    output logic            udpd_active,
    output logic            sram_lost,
    output logic            page_size_256,
    output logic [8:0]      page_bytes,
    // nonvolatile size cell
    output logic            nv_write,
    output logic            nv_write_256
);

    // ****************************************
    // frame receiver and timer
    // ****************************************
    ufc_frame_if frm ();

    ufc_byte_shifter u_shift (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .cs_n     (cs_n),
        .sck      (sck),
        .si       (si),
        .frm      (frm.shifter)
    );

    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic             tmr_done;

    ufc_timer #(.W(TMR_W)) u_tmr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // ****************************************
    // frame decode
    // ****************************************
    ufc_kind_t  kind, next_kind;
    logic       void_frame, next_void_frame;
    ufc_state_t state, next_state;

    always_comb
    begin
        next_kind       = kind;
        next_void_frame = void_frame;
        if (frm.frame_start)
        begin
            next_kind       = K_NONE;
            next_void_frame = (state != S_STANDBY);
        end
        else if (frm.byte_valid)
        begin
            unique case (kind)
                K_NONE:
                    if (frm.byte_data == OP_UDPD_ENTER)
                        next_kind = K_UDPD;
                    else if (frm.byte_data == OP_CFG_B0)
                        next_kind = K_CFG;
                    else
                        next_kind = K_BAD;
                K_UDPD:
                    next_kind = K_UDPD;
                K_CFG:
                    if (frm.byte_idx == 3'h1 && frm.byte_data == OP_CFG_B1)
                        next_kind = K_CFG;
                    else if (frm.byte_idx == 3'h2 && frm.byte_data == OP_CFG_B2)
                        next_kind = K_CFG;
                    else if (frm.byte_idx == 3'h3 && frm.byte_data == OP_CFG_256)
                        next_kind = K_CFG256;
                    else if (frm.byte_idx == 3'h3 && frm.byte_data == OP_CFG_264)
                        next_kind = K_CFG264;
                    else
                        next_kind = K_BAD;
                default:
                    next_kind = K_BAD;
            endcase
        end
    end

    // ****************************************
    // mode control
    // ****************************************
    logic [TMR_W-1:0] low_cnt, next_low_cnt;
    logic             size_256, next_size_256;
    logic             pend_256, next_pend_256;
    logic             nv_loaded, next_nv_loaded;
    logic             lost, next_lost;
    logic             go_cmd;

    assign go_cmd = frm.frame_end && !void_frame && frm.aligned && !ext_busy;

    always_comb
    begin
        next_state     = state;
        next_low_cnt   = low_cnt;
        next_size_256  = size_256;
        next_pend_256  = pend_256;
        next_nv_loaded = 1'b1;
        next_lost      = 1'b0;
        tmr_load       = 1'b0;
        tmr_val        = ENTRY_CYC;
        if (!nv_loaded)
            next_size_256 = nv_size_256;
        unique case (state)
            S_STANDBY:
                if (go_cmd && kind == K_UDPD)
                begin
                    next_state = S_ENTRY;
                    tmr_load   = 1'b1;
                end
                else if (go_cmd && (kind == K_CFG256 || kind == K_CFG264))
                begin
                    next_state    = S_CFG;
                    next_pend_256 = (kind == K_CFG256);
                    tmr_load      = 1'b1;
                    tmr_val       = CFG_CYC;
                end
            S_ENTRY:
                if (tmr_done)
                begin
                    next_state   = S_SLEEP;
                    next_lost    = 1'b1;
                    next_low_cnt = '0;
                end
            S_SLEEP:
                if (frm.frame_start)
                    next_low_cnt = '0;
                else if (frm.frame_end && low_cnt >= WAKE_CYC)
                begin
                    next_state = S_EXIT;
                    tmr_load   = 1'b1;
                    tmr_val    = EXIT_CYC;
                end
                else if (frm.cs_low && low_cnt != '1)
                    next_low_cnt = low_cnt + TMR_W'(1);
            S_EXIT:
                if (tmr_done)
                    next_state = S_STANDBY;
            S_CFG:
                if (tmr_done)
                begin
                    next_state    = S_STANDBY;
                    next_size_256 = pend_256;
                end
            default:
                next_state = S_STANDBY;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state      <= S_STANDBY;
            kind       <= K_NONE;
            void_frame <= 1'b0;
            low_cnt    <= '0;
            size_256   <= SIZE_256_RESET;
            pend_256   <= SIZE_256_RESET;
            nv_loaded  <= 1'b0;
            lost       <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            kind       <= next_kind;
            void_frame <= next_void_frame;
            low_cnt    <= next_low_cnt;
            size_256   <= next_size_256;
            pend_256   <= next_pend_256;
            nv_loaded  <= next_nv_loaded;
            lost       <= next_lost;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            device_idle_flag <= 1'b0;
            cmd_enable       <= 1'b0;
            udpd_active      <= 1'b0;
            sram_lost        <= 1'b0;
            page_size_256    <= SIZE_256_RESET;
            page_bytes       <= PAGE_BYTES_STD;
            nv_write         <= 1'b0;
            nv_write_256     <= SIZE_256_RESET;
        end
        else
        begin
            device_idle_flag <= (state == S_STANDBY) && !ext_busy;
            cmd_enable       <= (state == S_STANDBY);
            udpd_active      <= (state == S_SLEEP);
            sram_lost        <= lost;
            page_size_256    <= size_256;
            page_bytes       <= size_256 ? PAGE_BYTES_BIN : PAGE_BYTES_STD;
            nv_write         <= (state == S_CFG);
            nv_write_256     <= pend_256;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [TMR_W-1:0] age;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            age <= '0;
        else if (next_state != state)
            age <= '0;
        else if (age != '1)
            age <= age + TMR_W'(1);
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_udpd_release;
        state == S_STANDBY && frm.frame_end && !void_frame && frm.aligned && !ext_busy
            && kind == K_UDPD;
    endsequence

    sequence s_wake_release;
        state == S_SLEEP && frm.frame_end && low_cnt >= WAKE_CYC;
    endsequence

    sequence s_cfg_release;
        state == S_STANDBY && frm.frame_end && !void_frame && frm.aligned && !ext_busy
            && (kind == K_CFG256 || kind == K_CFG264);
    endsequence

    a_udpd_entry_taken: assert property (s_udpd_release |=> state == S_ENTRY)
        else $error("sleep opcode not taken");
    a_entry_time_bound: assert property (state == S_ENTRY |-> age < ENTRY_CYC)
        else $error("sleep entry too slow");
    a_short_frame_drop: assert property (state == S_STANDBY && frm.frame_end
        && !frm.aligned |=> state == S_STANDBY)
        else $error("misaligned frame acted on");
    a_busy_blocks_cmd: assert property (state == S_STANDBY && ext_busy
        |=> state == S_STANDBY)
        else $error("command taken while busy");
    a_sleep_cmd_block: assert property (state == S_SLEEP |=> ##1 !cmd_enable)
        else $error("commands enabled in sleep");
    a_sram_lost_pulse: assert property (state == S_ENTRY && tmr_done
        |=> ##1 sram_lost)
        else $error("buffer loss not flagged");
    a_wake_to_exit: assert property (s_wake_release |=> state == S_EXIT)
        else $error("wake pulse missed");
    a_exit_time_bound: assert property (state == S_EXIT |-> age < EXIT_CYC)
        else $error("sleep exit too slow");
    a_exit_frame_void: assert property (state == S_EXIT && frm.frame_start
        |=> void_frame)
        else $error("frame during exit not voided");
    a_cfg_busy_flag: assert property (state == S_CFG |=> !device_idle_flag)
        else $error("idle shown during size program");
    a_size_applied: assert property (state == S_CFG && tmr_done
        |=> size_256 == $past(pend_256) ##1 page_size_256 == $past(pend_256, 2))
        else $error("new page size not applied");
    a_page_bytes_map: assert property (page_bytes == (page_size_256
        ? PAGE_BYTES_BIN : PAGE_BYTES_STD))
        else $error("page byte count wrong");
    a_cfg_frame_taken: assert property (s_cfg_release |=> state == S_CFG)
        else $error("size command not taken");
    a_udpd_tail_kept: assert property (kind == K_UDPD && !frm.frame_start
        |=> kind == K_UDPD)
        else $error("bytes after sleep opcode acted on");
    a_sleep_no_cmd: assert property (state == S_SLEEP
        |=> state == S_SLEEP || state == S_EXIT)
        else $error("command acted on in sleep");
    a_exit_to_standby: assert property (state == S_EXIT && tmr_done
        |=> state == S_STANDBY ##1 cmd_enable)
        else $error("standby not regained");
    a_idle_when_free: assert property (state == S_STANDBY && !ext_busy
        |=> device_idle_flag)
        else $error("idle flag low with nothing running");
    a_nv_program_level: assert property (state == S_CFG
        |=> nv_write && nv_write_256 == $past(pend_256))
        else $error("size cell not written");
    a_cfg_bad_byte: assert property (kind == K_CFG && frm.byte_valid
        && !frm.frame_start && frm.byte_idx == 3'h3 && frm.byte_data != OP_CFG_256
        && frm.byte_data != OP_CFG_264 |=> kind == K_BAD)
        else $error("wrong size byte accepted");
    a_boot_standby: assert property (!nv_loaded |-> state == S_STANDBY)
        else $error("not in standby after power-up");
endmodule

// >>> ufc_pkg.sv
// constants, encodings and timing for the sleep and page-size command block
// assumes one 50 MHz core clock and spi pins already synchronous to it
package ufc_pkg;

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_UDPD_ENTER = 8'h79;
    localparam logic [7:0] OP_CFG_B0     = 8'h3d;
    localparam logic [7:0] OP_CFG_B1     = 8'h2a;
    localparam logic [7:0] OP_CFG_B2     = 8'h80;
    localparam logic [7:0] OP_CFG_256    = 8'ha6;
    localparam logic [7:0] OP_CFG_264    = 8'ha7;

    // ****************************************
    // page sizes
    // ****************************************
    localparam logic [8:0] PAGE_BYTES_BIN = 9'h100;
    localparam logic [8:0] PAGE_BYTES_STD = 9'h108;
    localparam logic       SIZE_256_RESET = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          ENTRY_TIME_NS   = 3000;
    localparam int          WAKE_LOW_NS     = 20;
    localparam int          EXIT_TIME_NS    = 100000;
    localparam int          CFG_PROG_NS     = 10000000;
    localparam int          TMR_W           = 20;
    localparam int          ENTRY_CYC_I     = (ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                              ENTRY_TIME_NS / CLK_PERIOD_NS;
    localparam int          WAKE_CYC_I      = (WAKE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          EXIT_CYC_I      = EXIT_TIME_NS / CLK_PERIOD_NS;
    localparam int          CFG_CYC_I       = CFG_PROG_NS / CLK_PERIOD_NS;
    localparam logic [TMR_W-1:0] ENTRY_CYC  = TMR_W'(ENTRY_CYC_I);
    localparam logic [TMR_W-1:0] WAKE_CYC   = TMR_W'((WAKE_CYC_I < 1) ? 1 : WAKE_CYC_I);

    // ****************************************
    // frame decode and states
    // ****************************************
    localparam logic [2:0] BYTE_IDX_MAX = 3'h7;

    typedef enum logic [2:0] {
        K_NONE   = 3'h0,
        K_UDPD   = 3'h1,
        K_CFG    = 3'h2,
        K_CFG256 = 3'h3,
        K_CFG264 = 3'h4,
        K_BAD    = 3'h5
    } ufc_kind_t;

    typedef enum logic [2:0] {
        S_STANDBY = 3'b000,
        S_ENTRY   = 3'b001,
        S_SLEEP   = 3'b011,
        S_EXIT    = 3'b010,
        S_CFG     = 3'b110
    } ufc_state_t;

endpackage

// >>> ufc_frame_if.sv
// byte-level view of the spi frame, passed from the shifter to the controller
// assumes all signals are registered in the core clock domain
`timescale 1ns/1ps
interface ufc_frame_if;
    logic       frame_start;
    logic       frame_end;
    logic       cs_low;
    logic       aligned;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic [2:0] byte_idx;

    modport shifter (output frame_start, frame_end, cs_low, aligned,
                     byte_valid, byte_data, byte_idx);
    modport ctrl    (input  frame_start, frame_end, cs_low, aligned,
                     byte_valid, byte_data, byte_idx);
endinterface

// >>> ufc_timer.sv
// down counter for the self-timed intervals
// assumes load and done are single-cycle events in the core clock domain
`timescale 1ns/1ps
module ufc_timer
    import ufc_pkg::*;
#(
    parameter int W = TMR_W
)(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // status
    output logic              done
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb
    begin
        if (load)
            next_cnt = load_val;
        else if (cnt != '0)
            next_cnt = cnt - W'(1);
        else
            next_cnt = cnt;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    // fires in the last counted cycle
    assign done = (cnt == W'(1)) && !load;
endmodule

// >>> ufc_byte_shifter.sv
// spi receive shifter: msb-first bytes on rising sck, frame edges, byte count
// assumes cs_n, sck and si are synchronous to core_clk, sck well below core_clk/2
`timescale 1ns/1ps
module ufc_byte_shifter
    import ufc_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // spi pins
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    // frame view
    ufc_frame_if.shifter frm
);
    logic       cs_q, sck_q;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [6:0] shf, next_shf;
    logic [2:0] idx, next_idx;
    logic       next_start, next_end, next_valid;
    logic [7:0] next_data;
    logic       rise;

    assign rise = sck && !sck_q && !cs_n;

    always_comb
    begin
        next_bit_cnt = bit_cnt;
        next_shf     = shf;
        next_idx     = idx;
        next_valid   = 1'b0;
        next_data    = frm.byte_data;
        next_start   = cs_q && !cs_n;
        next_end     = !cs_q && cs_n;
        if (next_start)
        begin
            next_bit_cnt = 3'h0;
            next_idx     = 3'h0;
        end
        if (rise)
        begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_shf     = {shf[5:0], si};
            if (bit_cnt == 3'h7)
            begin
                next_valid = 1'b1;
                next_data  = {shf, si};
                if (idx != BYTE_IDX_MAX)
                    next_idx = idx + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_q           <= 1'b1;
            sck_q          <= 1'b0;
            bit_cnt        <= 3'h0;
            shf            <= 7'h00;
            idx            <= 3'h0;
            frm.frame_start <= 1'b0;
            frm.frame_end  <= 1'b0;
            frm.cs_low     <= 1'b0;
            frm.aligned    <= 1'b1;
            frm.byte_valid <= 1'b0;
            frm.byte_data  <= 8'h00;
            frm.byte_idx   <= 3'h0;
        end
        else
        begin
            cs_q           <= cs_n;
            sck_q          <= sck;
            bit_cnt        <= next_bit_cnt;
            shf            <= next_shf;
            idx            <= next_idx;
            frm.frame_start <= next_start;
            frm.frame_end  <= next_end;
            frm.cs_low     <= !cs_n;
            frm.aligned    <= (bit_cnt == 3'h0);
            frm.byte_valid <= next_valid;
            frm.byte_data  <= next_data;
            frm.byte_idx   <= idx;
        end
    end
endmodule

// >>> ufc_spi_host.sv
// spi host model for the sleep and page-size command block
// assumes the device samples pins on rising core_clk; drives on falling edge
`timescale 1ns/1ps
module ufc_spi_host (
    // clock
    input  wire logic core_clk,
    // spi pins
    output logic      cs_n,
    output logic      sck,
    output logic      si
);
    logic idle_hi;

    initial
    begin
        cs_n    = 1'b1;
        sck     = 1'b0;
        si      = 1'b0;
        idle_hi = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // ****************************************
    // one frame, msb first, mode 0 or mode 3
    // ****************************************
    // sck idle level: 0 for mode 0, 1 for mode 3
    task automatic set_idle(input logic hi);
        tick(1);
        idle_hi = hi;
        sck     = hi;
    endtask

    task automatic frame(input logic [39:0] data, input int nbits);
        tick(2);
        cs_n = 1'b0;
        tick(2);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sck = 1'b0;
            si  = data[i];
            tick(2);
            sck = 1'b1;
            tick(2);
        end
        sck = idle_hi;
        tick(2);
        cs_n = 1'b1;
        si   = ~si;
    endtask

    // bare wake pulse, no clocks
    task automatic pulse(input int n);
        tick(2);
        cs_n = 1'b0;
        tick(n);
        cs_n = 1'b1;
        si   = ~si;
    endtask
endmodule

// >>> testbench.sv
// self-checking bench for the sleep and page-size command block
// assumes the host model drives the spi pins; exit and config counts shortened
`timescale 1ns/1ps
module testbench
    import ufc_pkg::*;
;
    localparam int EXIT_N = 20;
    localparam int CFG_N  = 40;
    logic core_clk, reset_n, ext_busy, nv_size_256;
    logic cs_n, sck, si;
    logic device_idle_flag, cmd_enable, udpd_active, sram_lost;
    logic page_size_256, nv_write, nv_write_256;
    logic [8:0] page_bytes;
    int num_errors = 0;
    int n_compared = 0;

    ufc_spi_host i_ufc_spi_host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si));

    ufc_udpd_cfg #(.EXIT_CYC(TMR_W'(EXIT_N)), .CFG_CYC(TMR_W'(CFG_N))) i_ufc_udpd_cfg (
        .core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
        .ext_busy(ext_busy), .nv_size_256(nv_size_256),
        .device_idle_flag(device_idle_flag), .cmd_enable(cmd_enable),
        .udpd_active(udpd_active), .sram_lost(sram_lost), .page_size_256(page_size_256),
        .page_bytes(page_bytes), .nv_write(nv_write), .nv_write_256(nv_write_256));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ****************************************
    // shared checks
    // ****************************************
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n)
        begin
            @(negedge core_clk);
            if (nv_write !== 1'b0 || udpd_active !== 1'b0)
                seen = 1'b1;
        end
        chk(9'(seen), 9'h0, "frame acted");
    endtask

    task automatic do_reset(input logic nv);
        reset_n     = 1'b0;
        nv_size_256 = nv;
        repeat (10) @(negedge core_clk);
        chk(page_bytes, 9'h108, "reset page size");
        reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(9'({cmd_enable, device_idle_flag, udpd_active}), 9'h6, "standby");
        chk(page_bytes, nv ? PAGE_BYTES_BIN : PAGE_BYTES_STD, "stored size");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_config(input logic [7:0] op);
        int n;
        logic bin;
        bin = (op == OP_CFG_256);
        i_ufc_spi_host.frame({8'h0, OP_CFG_B0, OP_CFG_B1, OP_CFG_B2, op}, 32);
        for (n = 0; n < 20 && nv_write !== 1'b1; n++) @(negedge core_clk);
        chk(9'({nv_write, nv_write_256}), 9'({1'b1, bin}), "nv program");
        chk(9'(device_idle_flag), 9'h0, "busy flag");
        for (n = 0; n < 200 && nv_write === 1'b1; n++) @(negedge core_clk);
        chk(9'(n >= CFG_N - 1 && n <= CFG_N + 1), 9'h1, "program length");
        @(negedge core_clk);
        chk(9'({page_size_256, device_idle_flag}), 9'({bin, 1'b1}), "size applied");
        chk(page_bytes, bin ? 9'h100 : 9'h108, "page bytes");
    endtask

    task automatic t_refused();
        logic [39:0] bad [4];
        int nb [4];
        bad = '{40'h3c, 40'h3cd, 40'h3d2a80a5, 40'h3d2a80a600};
        nb  = '{7, 11, 32, 40};
        for (int k = 0; k < 4; k++)
        begin
            i_ufc_spi_host.frame(bad[k], nb[k]);
            quiet(200);
            chk(page_bytes, 9'h108, "size kept");
        end
        ext_busy = 1'b1;
        @(negedge core_clk);
        chk(9'(device_idle_flag), 9'h0, "ext busy flag");
        i_ufc_spi_host.frame(40'h79, 8);
        quiet(200);
        ext_busy = 1'b0;
    endtask

    task automatic t_sleep(input logic extra);
        int n;
        if (extra)
            i_ufc_spi_host.frame(40'h79ff, 16);
        else
            i_ufc_spi_host.frame(40'h79, 8);
        for (n = 0; n < 300 && udpd_active !== 1'b1; n++) @(negedge core_clk);
        chk(9'(n <= ENTRY_CYC_I + 6), 9'h1, "entry time");
        chk(9'(sram_lost), 9'h1, "buffers lost");
        chk(9'({cmd_enable, device_idle_flag}), 9'h0, "commands blocked");
    endtask

    task automatic t_wake(input logic dummy);
        int n;
        logic wr;
        wr = 1'b0;
        if (dummy)
            i_ufc_spi_host.frame(40'h3d2a80a6, 32);
        else
            i_ufc_spi_host.pulse(2);
        for (n = 0; n < 300 && cmd_enable !== 1'b1; n++)
        begin
            @(negedge core_clk);
            wr = wr | (nv_write !== 1'b0);
        end
        chk(9'(n <= EXIT_N + 6), 9'h1, "exit time");
        chk(9'({wr, udpd_active}), 9'h0, "woke cleanly");
        chk(page_bytes, 9'h108, "size kept asleep");
    endtask

    // sleep and wake with sck idling high
    task automatic t_mode3();
        i_ufc_spi_host.set_idle(1'b1);
        t_sleep(1'b0);
        t_wake(1'b0);
        i_ufc_spi_host.set_idle(1'b0);
    endtask

    task automatic t_early_frame();
        t_sleep(1'b0);
        i_ufc_spi_host.pulse(2);
        i_ufc_spi_host.tick(6);
        i_ufc_spi_host.frame(40'h3d2a80a6, 32);
        quiet(100);
        chk(9'({cmd_enable, page_size_256}), 9'h2, "early frame dropped");
    endtask

    // ****************************************
    // verdict
    // ****************************************
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        reset_n     = 1'b0;
        ext_busy    = 1'b0;
        nv_size_256 = 1'b0;
        do_reset(1'b0);
        t_config(OP_CFG_256);
        t_config(OP_CFG_264);
        t_refused();
        t_sleep(1'b1);
        t_wake(1'b1);
        t_sleep(1'b0);
        t_wake(1'b0);
        t_mode3();
        t_early_frame();
        do_reset(1'b1);
        final_report();
    end

    initial
    begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end
endmodule
